// ### rtl/rce_cfg.svh
// Constants of the remote-control encoder: offsets, field positions, resets, timing
`ifndef RCE_CFG_SVH
`define RCE_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define RCE_OFS_CTRL        8'h00
`define RCE_OFS_STATUS      8'h04
`define RCE_OFS_LATCH       8'h08
`define RCE_OFS_CYCLES      8'h0C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RCE_CTRL_DSEL_BIT   0
`define RCE_CTRL_ALO_BIT    1
`define RCE_CTRL_AHI_BIT    2
`define RCE_ST_BUSY_BIT     0
`define RCE_ST_WORD_LSB     1
`define RCE_ST_BIT_LSB      3
`define RCE_ST_TRIG_BIT     8
`define RCE_LAT_DATA_LSB    10

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RCE_CTRL_RESET      3'h4

// ---------------------------------------------------------------
// Packet shape and timing
// ---------------------------------------------------------------
`define RCE_ADDR_BITS       10
`define RCE_DATA_BITS       8
`define RCE_WORDS           3
`define RCE_CLK_NS          100
`define RCE_SYM_PERIOD_NS   2000000
`define RCE_LAG_NS          150000000
`define RCE_FIFO_DEPTH      16

`endif

// ### rtl/rce_pkg.sv
// Types shared by the remote-control encoder
package rce_pkg;

  typedef enum logic [1:0] {
    SYM_ZERO,
    SYM_ONE,
    SYM_OPEN
  } rce_sym_type;

  typedef enum logic {
    ST_IDLE,
    ST_SEND
  } rce_state_type;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
    logic       dsel;
    logic       asel_hi;
    logic       asel_lo;
  } rce_frame_type;

  typedef struct packed {
    logic        word_end;
    rce_sym_type sym;
  } rce_out_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] ofs;
  } rce_bus_type;

endpackage

// ### rtl/rce_encoder.sv
// Remote-control encoder: pin sampling, packet serializer, symbol FIFO, AHB-Lite registers
//
// Operation
// R1 - Trigger high wakes encoder; cycle sends three identical packet words.
// R2 - While trigger stays high, a new cycle follows each finished one.
// R3 - Trigger low: finish running cycle, then return to standby.
// R4 - Packet order: address bits 0..9, then data bits 0..7.
// R5 - Each bit sent as one, zero or open per type selects.
// R6 - Lines resampled at every cycle start; changes need no trigger drop.
// R7 - Data change reaches the packet within 150 ms.
// R8 - Outside party must not set all ten address lines equal.
// R9 - Undriven address input reads high.
// R10 - Undriven data input reads low.
// R11 - Receiver ignores packets unless all address bits match.
// R12 - Receiver reproduces data; open bits shown as low.
// R13 - Trigger high at power-up starts transmission right away.
// R14 - Data select high: one/zero; low: one/open.
// R15 - Address selects hi,lo: 00 one/zero, 01 one/open, 10 open/zero, 11 one/zero.
// R16 - Selects default: data low, address upper high, lower low.
// R17 - Symbol timing from fixed divider with parameter period.
// R18 - All eighteen line states latched per cycle, held for three words.
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps

`include "rce_cfg.svh"

// ---------------------------------------------------------------
// Symbol FIFO
// ---------------------------------------------------------------
module rce_fifo
  import rce_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter int DEPTH = `RCE_FIFO_DEPTH
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_depth
    $error("rce_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW:0]      wr_reg;
  logic [PW:0]      rd_reg;
  wire              full  = (wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]);
  wire              empty = (wr_reg == rd_reg);
  wire              push  = ce && in_valid && !full;
  wire              pop   = ce && out_ready && !empty;

  assign in_ready  = !full;
  // Head is offered only while the enable runs, so a frozen FIFO is never taken twice
  assign out_valid = ce && !empty;
  assign out_data  = mem_reg[rd_reg[PW-1:0]];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop)  rd_reg <= rd_reg + 1'b1;
    end
  end

  // Storage needs no reset; nothing reads a slot before it is written
  always_ff @(posedge hclk) begin
    if (push) mem_reg[wr_reg[PW-1:0]] <= in_data;
  end
endmodule

// ---------------------------------------------------------------
// Encoder top
// ---------------------------------------------------------------
module rce_encoder
  import rce_pkg::*;
#(
  parameter int SYM_CYCLES = `RCE_SYM_PERIOD_NS / `RCE_CLK_NS,
  parameter int LAG_CYCLES = `RCE_LAG_NS / `RCE_CLK_NS,
  parameter int FIFO_DEPTH = `RCE_FIFO_DEPTH
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        tx_trigger,
  input  wire logic [9:0]  addr_in,
  input  wire logic [9:0]  addr_in_drive,
  input  wire logic [7:0]  data_in,
  input  wire logic [7:0]  data_in_drive,
  output logic             sym_valid,
  input  wire logic        sym_ready,
  output rce_sym_type      sym_data,
  output logic             sym_word_end,
  output logic             busy
);
  localparam int NBITS = `RCE_ADDR_BITS + `RCE_DATA_BITS;
  localparam int NPIN  = NBITS + 1;
  localparam int DW    = $clog2(SYM_CYCLES + 1);

  if (SYM_CYCLES < 1 || `RCE_WORDS * NBITS * SYM_CYCLES > LAG_CYCLES) begin : g_bad_sym // [R7]
    $error("rce_encoder: symbol period too long for the refresh lag");
  end

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  // Undriven lines take their pull level before the synchroniser
  wire [NPIN-1:0] pin_raw = {tx_trigger,
                             data_in & data_in_drive, // [R10]
                             addr_in | ~addr_in_drive}; // [R9]
  logic [NPIN-1:0] s1_reg;
  logic [NPIN-1:0] s2_reg;
  logic [NPIN-1:0] s3_reg;
  logic [NPIN-1:0] pin_reg;
  wire  [NPIN-1:0] pin_next;

  // A bit moves only once the second and third stages agree
  genvar gi;
  for (gi = 0; gi < NPIN; gi++) begin : g_filt
    assign pin_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : pin_reg[gi];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      pin_reg <= {1'b0, 8'h00, 10'h3FF};
    end else if (ce) begin
      s1_reg  <= pin_raw;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  wire trig = pin_reg[NPIN-1];

  // ---------------------------------------------------------------
  // Bit typing
  // ---------------------------------------------------------------
  function automatic rce_sym_type data_sym(input logic lvl, input logic dsel);
    if (lvl)       return SYM_ONE;
    else if (dsel) return SYM_ZERO; // [R14]
    else           return SYM_OPEN; // [R14]
  endfunction

  function automatic rce_sym_type addr_sym(input logic lvl, input logic hi, input logic lo);
    if (lvl) return (hi && !lo) ? SYM_OPEN : SYM_ONE; // [R15]
    else     return (!hi && lo) ? SYM_OPEN : SYM_ZERO; // [R15]
  endfunction

  // ---------------------------------------------------------------
  // Registers and serializer state
  // ---------------------------------------------------------------
  logic [2:0]    ctrl_reg;
  rce_frame_type lat_reg;
  rce_state_type state_reg;
  logic [1:0]    word_reg;
  logic [4:0]    bit_reg;
  logic [DW-1:0] div_reg;
  logic [31:0]   cycles_reg;
  rce_bus_type   bus_reg;
  logic [31:0]   hrdata_reg;

  wire         fifo_in_ready;
  wire         tick       = (div_reg == DW'(SYM_CYCLES - 1));
  wire         sending    = (state_reg == ST_SEND);
  wire         push       = ce && sending && tick && fifo_in_ready; // [R17]
  wire         last_bit   = (bit_reg == 5'(NBITS - 1));
  wire         word_end   = push && last_bit;
  wire         cycle_end  = word_end && (word_reg == 2'(`RCE_WORDS - 1)); // [R1]
  wire         start      = ce && !sending && trig; // [R1] [R13]
  wire         reload     = start || (cycle_end && trig); // [R2] [R6]
  wire         is_addr    = (bit_reg < 5'(`RCE_ADDR_BITS));
  wire [4:0]   data_idx   = bit_reg - 5'(`RCE_ADDR_BITS);
  wire         addr_lvl   = lat_reg.addr[bit_reg[3:0]];
  wire         data_lvl   = lat_reg.data[data_idx[2:0]];
  rce_sym_type cur_sym;
  assign cur_sym = is_addr ? addr_sym(addr_lvl, lat_reg.asel_hi, lat_reg.asel_lo)
                           : data_sym(data_lvl, lat_reg.dsel); // [R4] [R5]

  rce_frame_type lat_next;
  assign lat_next = '{addr: pin_reg[9:0], data: pin_reg[17:10],
                      dsel: ctrl_reg[`RCE_CTRL_DSEL_BIT],
                      asel_hi: ctrl_reg[`RCE_CTRL_AHI_BIT],
                      asel_lo: ctrl_reg[`RCE_CTRL_ALO_BIT]};

  rce_state_type state_next;
  assign state_next = reload ? ST_SEND : (cycle_end ? ST_IDLE : state_reg); // [R3]

  wire [DW-1:0] div_next = (reload || push) ? '0 : (tick ? div_reg : div_reg + 1'b1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      lat_reg   <= '0;
      word_reg  <= '0;
      bit_reg   <= '0;
      div_reg   <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      div_reg   <= div_next;
      if (reload) begin
        lat_reg  <= lat_next; // [R18] [R6]
        word_reg <= '0;
        bit_reg  <= '0;
      end else if (push) begin
        bit_reg  <= last_bit ? 5'h00 : bit_reg + 5'h01; // [R4]
        word_reg <= last_bit ? word_reg + 2'h1 : word_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Symbol FIFO towards the modulator
  // ---------------------------------------------------------------
  rce_out_type fifo_out;
  rce_out_type fifo_in;
  assign fifo_in = '{word_end: last_bit, sym: cur_sym};

  rce_fifo #(
    .WIDTH ($bits(rce_out_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .in_valid  (sending && tick),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (sym_valid),
    .out_ready (sym_ready),
    .out_data  (fifo_out)
  );

  assign sym_data     = fifo_out.sym;
  assign sym_word_end = fifo_out.word_end;
  assign busy         = sending;

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // Zero wait states; a low clock enable stalls the bus instead of losing a transfer
  wire       addr_phase = ce && hsel && hready && htrans[1];
  wire [7:0] ofs        = {haddr[7:2], 2'b00};
  wire       in_range   = (haddr[31:8] == 24'h000000);
  wire [31:0] status_word = {23'h0, trig, bit_reg, word_reg, sending};
  wire [31:0] latch_word  = {14'h0000, lat_reg.data, lat_reg.addr};
  wire [31:0] rd_word =
      !in_range                ? 32'h00000000 :
      (ofs == `RCE_OFS_CTRL)   ? {29'h00000000, ctrl_reg} :
      (ofs == `RCE_OFS_STATUS) ? status_word :
      (ofs == `RCE_OFS_LATCH)  ? latch_word :
      (ofs == `RCE_OFS_CYCLES) ? cycles_reg : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg    <= '0;
      hrdata_reg <= '0;
      ctrl_reg   <= `RCE_CTRL_RESET; // [R16]
      cycles_reg <= '0;
    end else if (ce) begin
      bus_reg.wr  <= addr_phase && hwrite && in_range;
      bus_reg.rd  <= addr_phase && !hwrite;
      bus_reg.ofs <= ofs;
      if (addr_phase && !hwrite) hrdata_reg <= rd_word;
      if (bus_reg.wr && bus_reg.ofs == `RCE_OFS_CTRL) ctrl_reg <= hwdata[2:0];
      if (cycle_end) cycles_reg <= cycles_reg + 32'h00000001;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = ce;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [31:0] lag_reg;
  logic        stall_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lag_reg   <= '0;
      stall_reg <= 1'b0;
    end else begin
      lag_reg   <= reload ? 32'h00000000 : (sending ? lag_reg + 32'h00000001 : lag_reg);
      stall_reg <= reload ? 1'b0 : (stall_reg || !ce || (sending && tick && !fifo_in_ready));
    end
  end

  sequence seq_cycle_done;
    ce && cycle_end;
  endsequence

  a_start_on_trig: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
    start |=> sending && word_reg == 2'h0 && bit_reg == 5'h00)
    else $error("encoder did not start on trigger");
  a_repeat_cycle: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
    seq_cycle_done ##0 trig |=> sending && word_reg == 2'h0)
    else $error("cycle not repeated while trigger high");
  a_stop_cycle: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    seq_cycle_done ##0 !trig |=> !sending)
    else $error("encoder did not stop after final cycle");
  a_no_early_stop: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    sending && !cycle_end |=> sending)
    else $error("cycle cut short");
  a_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [R18]
    sending && !reload |=> $stable(lat_reg))
    else $error("latched lines changed within a cycle");
  a_data_zero_sel: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
    push && !is_addr && cur_sym == SYM_ZERO |-> lat_reg.dsel && !data_lvl)
    else $error("data zero sent without select");
  a_addr_map_open: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
    push && is_addr && lat_reg.asel_hi && !lat_reg.asel_lo |-> cur_sym != SYM_ONE)
    else $error("address one sent in open/zero coding");
  a_refresh_lag: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
    sending && !stall_reg |-> lag_reg <= 32'(LAG_CYCLES))
    else $error("cycle exceeds refresh lag");
  a_word_order: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
    push && last_bit && word_reg != 2'h2 |=> bit_reg == 5'h00 && word_reg == $past(word_reg) + 2'h1)
    else $error("word sequencing broken");
endmodule

// ### bench/rce_decoder_model.sv
// Receiver/decoder model on the far side of the encoder's symbol stream
`timescale 1ns/10ps
module rce_decoder_model
  import rce_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        sym_valid,
  output logic             sym_ready,
  input  wire rce_sym_type sym_data,
  input  wire logic        sym_word_end,
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic [9:0]  local_addr,
  input  wire logic [2:0]  cfg,
  output logic             word_done,
  output logic [35:0]      word,
  output logic [4:0]       nsym,
  output logic [7:0]       data_out
);
  logic [35:0] acc;
  logic [35:0] full;
  logic [4:0]  idx;
  logic [3:0]  pace;
  logic        hit;

  // Local address is coded as the sender codes it, so both ends must share cfg
  function automatic logic [1:0] loc(input logic lvl);
    case (cfg[2:1])
      2'b01:   return lvl ? SYM_ONE : SYM_OPEN;
      2'b10:   return lvl ? SYM_OPEN : SYM_ZERO;
      default: return lvl ? SYM_ONE : SYM_ZERO;
    endcase
  endfunction

  // Slow mode answers on every other cycle only
  assign sym_ready = !stall && (!slow || pace[0]);
  assign full      = {sym_data, acc[33:0]};

  always_comb begin
    hit = 1'b1;
    for (int i = 0; i < 10; i++) begin
      if (full[2*i +: 2] != loc(local_addr[i])) hit = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx       <= '0;
      pace      <= '0;
      word_done <= 1'b0;
      data_out  <= '0;
    end else begin
      pace      <= pace + 4'h1;
      word_done <= 1'b0;
      if (sym_valid && sym_ready) begin
        acc[2*idx +: 2] <= sym_data;
        idx             <= idx + 5'h1;
        if (sym_word_end) begin
          word_done <= 1'b1;
          word      <= full;
          nsym      <= idx + 5'h1;
          idx       <= '0;
          for (int j = 0; j < 8; j++) begin
            if (hit) data_out[j] <= (full[20+2*j +: 2] == SYM_ONE);
          end
        end
      end
    end
  end
endmodule

// ### bench/tb_top.sv
// Testbench: encoder driven over AHB-Lite and pins, judged through a decoder model
`timescale 1ns/10ps
module tb_top;
  import rce_pkg::*;
  localparam int SYM = 4;
  localparam int LAG = 300;
  typedef struct packed {
    logic [35:0] w;
    logic [7:0]  d;
  } rce_note_type;
  logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]  haddr = '0, hwdata = '0, hrdata, rdv;
  logic [1:0]   htrans = '0;
  logic         hreadyout, hresp, sym_valid, sym_ready, sym_word_end, busy, word_done;
  logic         tx_trigger = 1'b1, stall = 1'b0, slow = 1'b0, miss = 1'b0, ce = 1'b1;
  logic [9:0]   addr_in = 10'h0F0, addr_drv = 10'h3C3;
  logic [7:0]   data_in = 8'hA5, data_drv = 8'h3C, data_out, last_d = '0;
  logic [2:0]   cfg = 3'h4;
  logic [35:0]  word;
  logic [4:0]   nsym;
  logic [31:0]  seed = 32'hE2BE;
  rce_sym_type  sym_data;
  rce_note_type q[$];
  rce_note_type cur;
  int           err_count = 0, checks = 0, rx_words = 0, cyc = 0, total = 0;
  wire [9:0]    ea = (addr_in & addr_drv) | ~addr_drv;
  wire [7:0]    ed = data_in & data_drv;

  rce_encoder #(.SYM_CYCLES(SYM), .LAG_CYCLES(LAG), .FIFO_DEPTH(16)) DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_trigger(tx_trigger), .addr_in(addr_in), .addr_in_drive(addr_drv),
    .data_in(data_in), .data_in_drive(data_drv), .sym_valid(sym_valid),
    .sym_ready(sym_ready), .sym_data(sym_data), .sym_word_end(sym_word_end), .busy(busy));
  rce_decoder_model rx (
    .hclk(hclk), .hresetn(hresetn), .sym_valid(sym_valid), .sym_ready(sym_ready),
    .sym_data(sym_data), .sym_word_end(sym_word_end), .stall(stall), .slow(slow),
    .local_addr(ea ^ {9'h0, miss}), .cfg(cfg), .word_done(word_done), .word(word),
    .nsym(nsym), .data_out(data_out));

  always #50 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'hA3000000 : seed >> 1;
    return seed;
  endfunction

  function automatic rce_sym_type enc(input logic lvl, input logic is_addr);
    if (!is_addr) return lvl ? SYM_ONE : (cfg[0] ? SYM_ZERO : SYM_OPEN);
    case (cfg[2:1])
      2'b01:   return lvl ? SYM_ONE : SYM_OPEN;
      2'b10:   return lvl ? SYM_OPEN : SYM_ZERO;
      default: return lvl ? SYM_ONE : SYM_ZERO;
    endcase
  endfunction

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check({hresp, v}, {1'b0, exp});
  endtask

  // Expected word from the line levels and selects in force right now
  task automatic note(input logic hit);
    rce_note_type n;
    for (int i = 0; i < 10; i++) n.w[2*i +: 2] = enc(ea[i], 1'b1);
    for (int j = 0; j < 8; j++) n.w[20+2*j +: 2] = enc(ed[j], 1'b0);
    n.d = hit ? ed : last_d;
    last_d = n.d;
    q.push_back(n);
  endtask

  task automatic new_lines();
    logic [31:0] r;
    r = rnd();
    @(posedge hclk);
    addr_in  <= r[9:0];
    addr_drv <= r[19:10];
    data_in  <= r[27:20];
    data_drv <= {r[31:28], r[3:0]};
    @(posedge hclk);
    if (ea == 10'h000 || ea == 10'h3FF) begin
      addr_in[0]  <= ~ea[0];
      addr_drv[0] <= 1'b1;
    end
    @(posedge hclk);
  endtask

  task automatic wait_words(input int n);
    while (rx_words < n) @(posedge hclk);
  endtask

  // Trigger falls once the last cycle's first word is received: that cycle must still finish
  task automatic run(input int ncyc, input logic chg, input logic m, input logic st);
    int base;
    int t0;
    base = rx_words;
    miss <= m;
    stall <= st;
    repeat ((ncyc == 2 && !chg) ? 6 : 3) note(!m);
    tx_trigger <= 1'b1;
    if (st) begin
      // Frozen enable first: the trigger must wait ahead of the synchroniser
      ce <= 1'b0;
      repeat (100) @(posedge hclk);
      ce <= 1'b1;
      repeat (300) @(posedge hclk);
      check(busy, 1);
      // Sixteen symbols fill the FIFO: word 0, bit 16, trigger and busy set
      rd_chk(32'h4, 32'h00000181);
      stall <= 1'b0;
    end
    wait_words(base + 1);
    if (chg) begin
      data_in  <= ~ed;
      data_drv <= 8'hFF;
      @(posedge hclk);
      t0 = cyc;
      repeat (3) note(1'b1);
      wait_words(base + 4);
      check(cyc - t0 <= LAG, 1);
    end
    if (ncyc == 2) wait_words(base + 4);
    tx_trigger <= 1'b0;
    @(posedge hclk);
    while (busy !== 1'b0) @(posedge hclk);
    repeat (150) @(posedge hclk);
    check(q.size(), 0);
    check(rx_words - base, 3 * ncyc);
    total += ncyc;
  endtask

  always @(posedge hclk) begin
    if (word_done === 1'b1) begin
      rx_words++;
      if (q.size() == 0) check(1, 0);
      else begin
        cur = q.pop_front();
        check(nsym, 18);
        check(word, cur.w);
        check(data_out, cur.d);
      end
    end
  end

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    check(busy, 1);
    run(1, 0, 0, 0);
    rd_chk(32'h0, 32'h4);
    for (int k = 0; k < 8; k++) begin
      cfg  <= k[2:0];
      slow <= k[0];
      ahb(1'b1, 32'h0, 32'(k), rdv);
      new_lines();
      run(1, 0, 0, 0);
      rd_chk(32'h8, {14'h0, ed, ea});
    end
    run(2, 0, 0, 0);
    run(2, 1, 0, 0);
    run(1, 0, 1, 0);
    run(1, 0, 0, 1);
    ahb(1'b1, 32'hC, 32'hFFFFFFFF, rdv);
    rd_chk(32'hC, total);
    rd_chk(32'h100, 32'h0);
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge hclk);
    err_count++;
    end_sim();
  end
endmodule
